// ---- core/interval_timer.sv ----
// 16-bit interval timer with AHB-Lite register slave and level interrupt.
// Assumes a single AHB-Lite master; the external clock pin is asynchronous.
//
// Behaviour
// - The timer is 16 bits and runs as timer, synchronous counter or asynchronous counter.
// - The count is readable and writable so it serves as interval timer or clock counter.
// - An event is raised on period match, or in gated mode on the gate's falling edge.
// - Control bit 13 set halts the timer in Idle; clear lets it count on in Idle.
// - Control bits 5-4 divide the input clock by 1, 8, 64 or 256.
// - Control bit 2 picks a synchronised or direct external edge, ignored on internal clock.
// - Control bit 1 selects rising edges of the external pin, else the internal clock.
// - Unimplemented control bits read as zero and ignore writes.
//
// The register offsets and the AHB-Lite register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "interval_timer_consts.svh"

module interval_timer #(
  parameter int PRESCALE_WIDTH = 8
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Device power state
  input  wire logic        idle_mode,
  // External clock or gate pin
  input  wire logic        external_timer_clock_pin,
  // Interrupt
  output logic             irq
);

  interval_timer_pkg::timer_state_t s;
  interval_timer_pkg::timer_state_t next_s;

  logic        timer_run_bit;
  logic        stop_in_idle_bit;
  logic        gate_accumulate_enable;
  logic [1:0]  prescale_select;
  logic        external_clock_sync_select;
  logic        clock_source_select;
  logic        gated;
  logic        run;
  logic        ext_rise;
  logic        gate_fall;
  logic        raw_tick;
  logic        pre_in;
  logic        pre_tick;
  logic        pre_clear;
  logic        count_wr;
  logic        match_evt;
  logic        accept;
  logic [2:0]  acc_idx;
  logic [1:0]  set_evt;
  logic [1:0]  rd_clear;

  initial begin
    if (PRESCALE_WIDTH != 8) begin
      $error("interval_timer: PRESCALE_WIDTH must be 8");
    end
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic [2:0] reg_index(input logic [31:0] addr);
    case (addr[7:0])
      `TMR_OFS_CTRL:   reg_index = `TMR_IDX_CTRL;
      `TMR_OFS_PERIOD: reg_index = `TMR_IDX_PERIOD;
      `TMR_OFS_COUNT:  reg_index = `TMR_IDX_COUNT;
      `TMR_OFS_STATUS: reg_index = `TMR_IDX_STATUS;
      `TMR_OFS_MASK:   reg_index = `TMR_IDX_MASK;
      default:         reg_index = `TMR_IDX_NONE;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  assign timer_run_bit              = s.ctrl[`TMR_BIT_RUN];
  assign stop_in_idle_bit           = s.ctrl[`TMR_BIT_SIDL];
  assign gate_accumulate_enable     = s.ctrl[`TMR_BIT_GATE];
  assign prescale_select            = s.ctrl[`TMR_BIT_PS_HI:`TMR_BIT_PS_LO];
  assign external_clock_sync_select = s.ctrl[`TMR_BIT_SYNC];
  assign clock_source_select        = s.ctrl[`TMR_BIT_CS];

  // ----------------------------------------------------------------
  // Tick source
  // ----------------------------------------------------------------
  // gate on internal only
  assign gated = gate_accumulate_enable & ~clock_source_select;
  assign run = timer_run_bit & ~(idle_mode & stop_in_idle_bit);
  assign ext_rise  = s.pin_s2 & ~s.pin_s3;
  assign gate_fall = ~s.pin_s2 & s.pin_s3;

  always_comb begin
    if (clock_source_select) begin
      raw_tick = external_clock_sync_select ? s.edge_q : ext_rise;
    end else if (gated) begin
      raw_tick = s.pin_s2;
    end else begin
      raw_tick = 1'b1;
    end
  end

  assign pre_in    = run & raw_tick;
  assign count_wr  = s.wr_pend & (s.wr_idx == `TMR_IDX_COUNT);
  assign pre_clear = count_wr | (s.wr_pend & (s.wr_idx == `TMR_IDX_CTRL));

  timer_prescaler #(
    .WIDTH (PRESCALE_WIDTH)
  ) u_prescaler (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .select   (prescale_select),
    .clear    (pre_clear),
    .tick_in  (pre_in),
    .tick_out (pre_tick)
  );

  assign match_evt = pre_tick & (s.count == s.period);
  assign accept    = hready & hsel & htrans[1] & (hsize == `TMR_HSIZE_WORD);
  assign acc_idx   = reg_index(haddr);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    set_evt = 2'h0;
    rd_clear = 2'h0;

    // Pin synchroniser and edge history
    next_s.pin_s1 = external_timer_clock_pin;
    next_s.pin_s2 = s.pin_s1;
    next_s.pin_s3 = s.pin_s2;
    next_s.edge_q = ext_rise;

    if (pre_tick) begin
      if (match_evt) begin
        next_s.count = `TMR_COUNT_RST;
      end else begin
        next_s.count = s.count + 16'h0001;
      end
    end

    set_evt[`TMR_EVT_MATCH] = match_evt & ~gated;
    set_evt[`TMR_EVT_GATE]  = gate_fall & gated & timer_run_bit;

    // Data phase of a write
    if (s.wr_pend) begin
      case (s.wr_idx)
        `TMR_IDX_CTRL: begin
          next_s.ctrl = hwdata[15:0] & `TMR_CTRL_WMASK;
        end
        `TMR_IDX_PERIOD: begin
          next_s.period = hwdata[15:0];
        end
        `TMR_IDX_COUNT: begin
          next_s.count = hwdata[15:0];
        end
        `TMR_IDX_MASK: begin
          next_s.mask = hwdata[1:0];
        end
        default: begin
          next_s.mask = s.mask;
        end
      endcase
    end

    // Address phase
    next_s.wr_pend = accept & hwrite;
    next_s.wr_idx  = acc_idx;
    next_s.hrdata  = 32'h0000_0000;
    if (accept & ~hwrite) begin
      case (acc_idx)
        `TMR_IDX_CTRL:   next_s.hrdata = {16'h0000, next_s.ctrl};
        `TMR_IDX_PERIOD: next_s.hrdata = {16'h0000, next_s.period};
        `TMR_IDX_COUNT:  next_s.hrdata = {16'h0000, next_s.count};
        `TMR_IDX_STATUS: begin
          next_s.hrdata = {30'h0000_0000, s.status};
          rd_clear = s.status;
        end
        `TMR_IDX_MASK:   next_s.hrdata = {30'h0000_0000, next_s.mask};
        default:         next_s.hrdata = 32'h0000_0000;
      endcase
    end

    // Sticky flags: a set in the clearing cycle wins
    next_s.status    = (s.status & ~rd_clear) | set_evt;
    next_s.irq       = |(next_s.status & next_s.mask);
    next_s.hreadyout = 1'b1;
    next_s.hresp     = `TMR_HRESP_OKAY;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s           <= '0;
      s.ctrl      <= `TMR_CTRL_RST;
      s.period    <= `TMR_PERIOD_RST;
      s.count     <= `TMR_COUNT_RST;
      s.status    <= `TMR_EVT_RST;
      s.mask      <= `TMR_EVT_RST;
      s.wr_idx    <= `TMR_IDX_NONE;
      s.hreadyout <= 1'b1;
      s.hresp     <= `TMR_HRESP_OKAY;
    end else begin
      s <= next_s;
    end
  end

  assign hreadyout = s.hreadyout;
  assign hresp     = s.hresp;
  assign hrdata    = s.hrdata;
  assign irq       = s.irq;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic rd_ctrl_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_ctrl_q <= 1'b0;
    end else begin
      rd_ctrl_q <= accept & ~hwrite & (acc_idx == `TMR_IDX_CTRL);
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  property p_reserved_zero;
    rd_ctrl_q |-> (hrdata[15:0] & ~`TMR_CTRL_WMASK) == 16'h0000 && hrdata[31:16] == 16'h0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved control bits read nonzero");

  property p_stopped_holds;
    !timer_run_bit && !count_wr |=> $stable(s.count);
  endproperty
  a_stopped_holds: assert property (p_stopped_holds)
    else $error("count moved while stopped");

  property p_wrap;
    match_evt && !count_wr |=> s.count == 16'h0000;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("count did not wrap on period match");

  property p_idle_halt;
    stop_in_idle_bit && idle_mode && !count_wr |=> $stable(s.count);
  endproperty
  a_idle_halt: assert property (p_idle_halt)
    else $error("count moved in idle with stop bit set");

  property p_increment;
    pre_tick && !match_evt && !count_wr |=> s.count == $past(s.count) + 16'h0001;
  endproperty
  a_increment: assert property (p_increment)
    else $error("count did not advance by one");

  property p_div8_spacing;
    pre_tick && prescale_select == 2'h1 && !pre_clear |=> !pre_tick [*7];
  endproperty
  a_div8_spacing: assert property (p_div8_spacing)
    else $error("divide-by-8 ticks too close");

  property p_gate_flag;
    gate_fall && gated && timer_run_bit |=> s.status[`TMR_EVT_GATE] ##1 irq || !s.mask[1];
  endproperty
  a_gate_flag: assert property (p_gate_flag)
    else $error("gate falling edge did not raise flag");

  property p_gate_low_holds;
    gated && !s.pin_s2 && !count_wr |=> $stable(s.count);
  endproperty
  a_gate_low_holds: assert property (p_gate_low_holds)
    else $error("count moved with gate low");

  property p_ext_no_edge;
    clock_source_select && !external_clock_sync_select && !ext_rise && !count_wr
      |=> $stable(s.count);
  endproperty
  a_ext_no_edge: assert property (p_ext_no_edge)
    else $error("external mode counted without an edge");

  property p_sync_delay;
    clock_source_select && external_clock_sync_select && run && !pre_clear
      && prescale_select == 2'h0 && ext_rise |=> pre_tick;
  endproperty
  a_sync_delay: assert property (p_sync_delay)
    else $error("synchronised edge not counted one cycle later");

  property p_match_flag;
    match_evt && !gated |=> s.status[`TMR_EVT_MATCH];
  endproperty
  a_match_flag: assert property (p_match_flag)
    else $error("period match did not set its flag");

  property p_div1_every;
    pre_in && prescale_select == 2'h0 && !pre_clear |-> pre_tick;
  endproperty
  a_div1_every: assert property (p_div1_every)
    else $error("divide-by-1 missed an input tick");

  property p_ext_no_gate;
    clock_source_select && !s.status[`TMR_EVT_GATE] |=> !s.status[`TMR_EVT_GATE];
  endproperty
  a_ext_no_gate: assert property (p_ext_no_gate)
    else $error("gate flag raised with external clock selected");

  c_match: cover property (match_evt && !gated);
  c_gate_fall: cover property (gate_fall && gated && timer_run_bit);
  c_ext_count: cover property (clock_source_select && pre_tick);
  c_irq: cover property (!irq ##1 irq);
  c_idle_halt: cover property (idle_mode && stop_in_idle_bit && timer_run_bit);

endmodule // interval_timer
`default_nettype wire

// ---- core/interval_timer_consts.svh ----
// Constants of the 16-bit interval timer: register map, control bit
// positions, reset values and prescaler terminal counts.
// Assumes inclusion by bare name from the design and bench files.
`ifndef INTERVAL_TIMER_CONSTS_SVH
`define INTERVAL_TIMER_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte offsets (word aligned)
// ----------------------------------------------------------------
`define TMR_OFS_CTRL        8'h00
`define TMR_OFS_PERIOD      8'h04
`define TMR_OFS_COUNT       8'h08
`define TMR_OFS_STATUS      8'h0c
`define TMR_OFS_MASK        8'h10

// ----------------------------------------------------------------
// Register indices inside the block
// ----------------------------------------------------------------
`define TMR_IDX_CTRL        3'h0
`define TMR_IDX_PERIOD      3'h1
`define TMR_IDX_COUNT       3'h2
`define TMR_IDX_STATUS      3'h3
`define TMR_IDX_MASK        3'h4
`define TMR_IDX_NONE        3'h7

// ----------------------------------------------------------------
// Control register bit positions
// ----------------------------------------------------------------
`define TMR_BIT_RUN         15
`define TMR_BIT_SIDL        13
`define TMR_BIT_GATE        6
`define TMR_BIT_PS_HI       5
`define TMR_BIT_PS_LO       4
`define TMR_BIT_SYNC        2
`define TMR_BIT_CS          1
`define TMR_CTRL_WMASK      16'ha076

// ----------------------------------------------------------------
// Status and mask bit positions
// ----------------------------------------------------------------
`define TMR_EVT_MATCH       0
`define TMR_EVT_GATE        1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TMR_CTRL_RST        16'h0000
`define TMR_PERIOD_RST      16'hffff
`define TMR_COUNT_RST       16'h0000
`define TMR_EVT_RST         2'h0

// ----------------------------------------------------------------
// Prescaler terminal counts (ratio minus one)
// ----------------------------------------------------------------
`define TMR_PS_DIV1         8'h00
`define TMR_PS_DIV8         8'h07
`define TMR_PS_DIV64        8'h3f
`define TMR_PS_DIV256       8'hff

// ----------------------------------------------------------------
// Bus constants
// ----------------------------------------------------------------
`define TMR_HSIZE_WORD      3'h2
`define TMR_HRESP_OKAY      1'b0

`endif

// ---- core/interval_timer_pkg.sv ----
// Types of the 16-bit interval timer: state records of both modules.
// Assumes interval_timer_consts.svh holds the numbers.
`default_nettype none

package interval_timer_pkg;

  // ----------------------------------------------------------------
  // Prescaler state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] count;
  } prescaler_state_t;

  // ----------------------------------------------------------------
  // Timer state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] period;
    logic [15:0] count;
    logic [1:0]  status;
    logic [1:0]  mask;
    logic        pin_s1;
    logic        pin_s2;
    logic        pin_s3;
    logic        edge_q;
    logic        wr_pend;
    logic [2:0]  wr_idx;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        irq;
  } timer_state_t;

endpackage

`default_nettype wire

// ---- core/timer_prescaler.sv ----
// Prescaler of the interval timer: passes one input tick in 1, 8, 64
// or 256 onward. Assumes ticks and controls come from the hclk domain.
`timescale 1ns/10ps
`default_nettype none
`include "interval_timer_consts.svh"

module timer_prescaler #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Control
  input  wire logic [1:0] select,
  input  wire logic       clear,
  // Ticks
  input  wire logic       tick_in,
  output logic            tick_out
);

  interval_timer_pkg::prescaler_state_t s;
  interval_timer_pkg::prescaler_state_t next_s;

  initial begin
    if (WIDTH != 8) begin
      $error("timer_prescaler: WIDTH must be 8");
    end
  end

  function automatic logic [7:0] terminal(input logic [1:0] sel);
    case (sel)
      2'h0:    terminal = `TMR_PS_DIV1;
      2'h1:    terminal = `TMR_PS_DIV8;
      2'h2:    terminal = `TMR_PS_DIV64;
      default: terminal = `TMR_PS_DIV256;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    tick_out = 1'b0;
    if (clear) begin
      next_s.count = 8'h00;
    end else if (tick_in) begin
      if (s.count >= terminal(select)) begin
        next_s.count = 8'h00;
        tick_out = 1'b1;
      end else begin
        next_s.count = s.count + 8'h01;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule // timer_prescaler
`default_nettype wire

// ---- dv/ext_pin_source.sv ----
// Far-side model of the timer's external pin: clock edges and gate pulses.
// Assumes the bench calls its tasks from the hclk domain.
`timescale 1ns/10ps
`default_nettype none

module ext_pin_source (
  // Clock
  input  wire logic hclk,
  // External pin
  output var logic  pin
);
  // ------------------------------------------------------------
  // Pin idles low between frames
  // ------------------------------------------------------------
  initial pin = 1'b0;

  task automatic edges(input int n, input int half);
    repeat (n) begin
      repeat (half) @(posedge hclk);
      pin <= 1'b1;
      repeat (half) @(posedge hclk);
      pin <= 1'b0;
    end
  endtask

  task automatic gate(input int len);
    @(posedge hclk);
    pin <= 1'b1;
    repeat (len) @(posedge hclk);
    pin <= 1'b0;
  endtask
endmodule // ext_pin_source

`default_nettype wire

// ---- dv/sixteen_bit_interval_timer_tb.sv ----
// Self-checking bench of the interval timer over AHB-Lite.
// Assumes ext_pin_source drives the external pin; hready is hreadyout.
`timescale 1ns/10ps
`default_nettype none
`include "interval_timer_consts.svh"

module sixteen_bit_interval_timer_tb;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        idle_mode;
  logic        ext_pin;
  logic        irq;
  logic [31:0] rdat;
  int          miscompares;
  int          n_checks;
  int          sh[4]       = '{0, 3, 6, 8};
  logic [31:0] ext_ctrl[3] = '{32'h8002, 32'h8006, 32'h8042};
  int          half[3]     = '{1, 4, 2};

  interval_timer #(.PRESCALE_WIDTH(8)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .idle_mode(idle_mode),
    .external_timer_clock_pin(ext_pin), .irq(irq)
  );

  ext_pin_source src (.hclk(hclk), .pin(ext_pin));

  always #2 hclk = ~hclk;

  // ------------------------------------------------------------
  // Bus cycles and comparisons
  // ------------------------------------------------------------
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] q);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d, rdat);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask

  task automatic chk(input logic [31:0] act, input logic [31:0] exp, input string what);
    n_checks++;
    if (act !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, act, exp);
    end
  endtask

  task automatic chk_rng(input logic [31:0] act, input int lo, input int hi, input string what);
    n_checks++;
    if ((act >= 32'(lo) && act <= 32'(hi)) !== 1'b1) begin
      miscompares++;
      $display("MISMATCH at %0t: %s got %0d expected %0d..%0d", $time, what, act, lo, hi);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    bus(a, 1'b0, 32'h0, rdat);
    chk(rdat, exp, what);
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Watchdog
  // ------------------------------------------------------------
  initial begin
    cyc(40000);
    miscompares++;
    end_of_test;
  end

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = `TMR_HSIZE_WORD;
    hwdata = 32'h0;
    idle_mode = 1'b0;
    miscompares = 0;
    n_checks = 0;
    cyc(16);
    hresetn <= 1'b1;
    cyc(1);
    chk({31'h0, irq}, 32'h0, "irq after reset");
    rd_chk(`TMR_OFS_CTRL, 32'h0, "ctrl reset");
    rd_chk(`TMR_OFS_PERIOD, 32'hffff, "period reset");
    rd_chk(`TMR_OFS_COUNT, 32'h0, "count reset");
    rd_chk(`TMR_OFS_STATUS, 32'h0, "status reset");
    rd_chk(`TMR_OFS_MASK, 32'h0, "mask reset");
    rd_chk(8'h14, 32'h0, "unmapped read");
    wr(`TMR_OFS_CTRL, 32'hffffffff);
    rd_chk(`TMR_OFS_CTRL, 32'ha076, "ctrl writable bits");
    wr(`TMR_OFS_CTRL, 32'h0);
    wr(`TMR_OFS_COUNT, 32'h1234);
    cyc(50);
    rd_chk(`TMR_OFS_COUNT, 32'h1234, "stopped count holds");
    // Period match with interrupt masked, then unmasked
    wr(`TMR_OFS_PERIOD, 32'h2);
    wr(`TMR_OFS_COUNT, 32'h0);
    wr(`TMR_OFS_CTRL, 32'h8000);
    cyc(20);
    wr(`TMR_OFS_CTRL, 32'h0);
    chk({31'h0, irq}, 32'h0, "masked irq");
    bus(`TMR_OFS_COUNT, 1'b0, 32'h0, rdat);
    chk_rng(rdat, 0, 2, "count wraps at period");
    wr(`TMR_OFS_MASK, 32'h1);
    cyc(2);
    chk({31'h0, irq}, 32'h1, "unmasked irq");
    rd_chk(`TMR_OFS_STATUS, 32'h1, "match flag");
    cyc(2);
    chk({31'h0, irq}, 32'h0, "irq after status read");
    wr(`TMR_OFS_STATUS, 32'h3);
    rd_chk(`TMR_OFS_STATUS, 32'h0, "status ignores writes");
    wr(`TMR_OFS_PERIOD, 32'hffff);
    // Every prescale ratio
    for (int i = 0; i < 4; i++) begin
      wr(`TMR_OFS_COUNT, 32'h0);
      wr(`TMR_OFS_CTRL, 32'h8000 + 32'(i) * 32'h10);
      cyc(2048);
      wr(`TMR_OFS_CTRL, 32'h0);
      bus(`TMR_OFS_COUNT, 1'b0, 32'h0, rdat);
      chk_rng(rdat, (2048 >> sh[i]) - 1, (2048 >> sh[i]) + 4, "prescaled count");
    end
    // Idle with and without stop-in-idle
    idle_mode <= 1'b1;
    wr(`TMR_OFS_COUNT, 32'h0);
    wr(`TMR_OFS_CTRL, 32'ha000);
    cyc(100);
    wr(`TMR_OFS_CTRL, 32'h0);
    rd_chk(`TMR_OFS_COUNT, 32'h0, "halted in idle");
    wr(`TMR_OFS_COUNT, 32'h0);
    wr(`TMR_OFS_CTRL, 32'h8000);
    cyc(100);
    wr(`TMR_OFS_CTRL, 32'h0);
    bus(`TMR_OFS_COUNT, 1'b0, 32'h0, rdat);
    chk_rng(rdat, 100, 104, "counts in idle");
    idle_mode <= 1'b0;
    // External clock: direct, synchronised, gate bit ignored
    for (int i = 0; i < 3; i++) begin
      wr(`TMR_OFS_COUNT, 32'h0);
      wr(`TMR_OFS_CTRL, ext_ctrl[i]);
      src.edges(10, half[i]);
      cyc(8);
      wr(`TMR_OFS_CTRL, 32'h0);
      rd_chk(`TMR_OFS_COUNT, 32'ha, "external edges");
    end
    // Gated accumulation and gate falling edge event
    wr(`TMR_OFS_MASK, 32'h2);
    wr(`TMR_OFS_COUNT, 32'h0);
    wr(`TMR_OFS_CTRL, 32'h8040);
    src.gate(50);
    cyc(8);
    chk({31'h0, irq}, 32'h1, "gate irq");
    wr(`TMR_OFS_CTRL, 32'h0);
    bus(`TMR_OFS_COUNT, 1'b0, 32'h0, rdat);
    chk_rng(rdat, 49, 51, "gated count");
    rd_chk(`TMR_OFS_STATUS, 32'h2, "gate flag");
    cyc(2);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    chk({31'h0, hresp}, 32'h0, "response okay");
    end_of_test;
  end
endmodule // sixteen_bit_interval_timer_tb

`default_nettype wire
